/* File: rtl/crpm_defines.svh */
// constants of the lock monitor and ppm tolerance slice
`ifndef CRPM_DEFINES_SVH
`define CRPM_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CRPM_ADDR_W 8
`define CRPM_DATA_W 8
`define CRPM_OFS_LOCK_PWR 8'h34
`define CRPM_OFS_PPM_TOL 8'h35
`define CRPM_RD_UNMAPPED 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define CRPM_BIT_PPM_RDY 7
`define CRPM_BIT_LP_DIS 6
`define CRPM_FLD_RECHK_HI 5
`define CRPM_FLD_RECHK_LO 4
`define CRPM_FLD_SCALE_HI 7
`define CRPM_FLD_SCALE_LO 6
`define CRPM_BIT_FETCH 5
`define CRPM_FLD_FRAC_HI 3
`define CRPM_FLD_FRAC_LO 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define CRPM_RST_LOCK_PWR 8'h3F
`define CRPM_RST_PPM_TOL 8'h1F

// ----------------------------------------
// tolerance scale codes
// ----------------------------------------
`define CRPM_SCALE_X1 2'h0
`define CRPM_SCALE_X1P 2'h1
`define CRPM_SCALE_X2 2'h2
`define CRPM_SCALE_X2P 2'h3

// ----------------------------------------
// widths and timing
// ----------------------------------------
`define CRPM_PPM_W 16
`define CRPM_TOL_W 10
`define CRPM_PD_CNT_W 24
`define CRPM_PD_TIME_MS 100
`define CRPM_CLK_MHZ 100
`define CRPM_CYC_PER_MS_MHZ 1000

`endif

/* File: rtl/crpm_pkg.sv */
// types of the lock monitor and ppm tolerance slice
`include "crpm_defines.svh"

package crpm_pkg;

    typedef enum logic [1:0] {
        LK_UNLOCKED,
        LK_LOCKED,
        LK_RECHECK
    } crpm_lock_state_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } crpm_sync_type;

    typedef struct packed {
        crpm_lock_state_type lock_state;
        logic [1:0] recheck_cnt;
        logic lock;
        logic [`CRPM_DATA_W-1:0] lock_pwr;
        logic [`CRPM_DATA_W-1:0] ppm_tol;
        logic [`CRPM_PPM_W-1:0] ppm_result;
        logic [`CRPM_TOL_W-1:0] tol_scaled;
        logic [`CRPM_PD_CNT_W-1:0] pd_cnt;
        logic power_down;
        logic [`CRPM_DATA_W-1:0] rdata;
    } crpm_state_type;

endpackage

/* File: rtl/crpm_sync.sv */
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none

module crpm_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);

    localparam crpm_pkg::crpm_sync_type RST = '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, q: RESET_VAL};

    crpm_pkg::crpm_sync_type st_ff;
    crpm_pkg::crpm_sync_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // a change counts only once the last two stages agree
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.q = st_ff.s3;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;

endmodule

`default_nettype wire

/* File: rtl/crpm_top.sv */
// per-channel cdr lock monitor, ppm tolerance scaling, ppm capture and power-down timer
`timescale 1ns/1ps
`default_nettype none
`include "crpm_defines.svh"

module crpm_top #(
    parameter int unsigned PD_CYCLES = `CRPM_PD_TIME_MS * `CRPM_CYC_PER_MS_MHZ * `CRPM_CLK_MHZ
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`CRPM_ADDR_W-1:0] reg_addr,
    input wire logic [`CRPM_DATA_W-1:0] reg_wdata,
    output logic [`CRPM_DATA_W-1:0] reg_rdata,
    input wire logic sig_detect,
    input wire logic lock_crit_ok,
    input wire logic lock_check_tick,
    input wire logic [`CRPM_PPM_W-1:0] ppm_count,
    input wire logic ppm_count_valid,
    input wire logic [`CRPM_DATA_W-1:0] ppm_delta_base,
    output logic cdr_lock,
    output logic power_down,
    output logic [`CRPM_PPM_W-1:0] ppm_result,
    output logic [`CRPM_TOL_W-1:0] ppm_tol_scaled
);

    localparam logic [`CRPM_PD_CNT_W-1:0] PD_LAST = `CRPM_PD_CNT_W'(PD_CYCLES - 1);

    localparam crpm_pkg::crpm_state_type RST = '{
        lock_state: crpm_pkg::LK_UNLOCKED,
        recheck_cnt: 2'h0,
        lock: 1'b0,
        lock_pwr: `CRPM_RST_LOCK_PWR,
        ppm_tol: `CRPM_RST_PPM_TOL,
        ppm_result: `CRPM_PPM_W'(0),
        tol_scaled: `CRPM_TOL_W'(0),
        pd_cnt: `CRPM_PD_CNT_W'(0),
        power_down: 1'b0,
        rdata: `CRPM_RD_UNMAPPED
    };

    crpm_pkg::crpm_state_type st_ff;
    crpm_pkg::crpm_state_type nxt_st;

    logic sd_sync;
    logic crit_sync;
    logic [1:0] recheck_max;
    logic [1:0] scale;
    logic [`CRPM_TOL_W-1:0] base_w;
    logic [`CRPM_TOL_W-1:0] frac_w;
    logic wr_lock_pwr;
    logic wr_ppm_tol;

    // ----------------------------------------
    // pin input synchronisers
    // ----------------------------------------
    crpm_sync #(.RESET_VAL(1'b0)) u_sync_sd (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(sig_detect),
        .q(sd_sync)
    );

    crpm_sync #(.RESET_VAL(1'b0)) u_sync_crit (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(lock_crit_ok),
        .q(crit_sync)
    );

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    assign recheck_max = st_ff.lock_pwr[`CRPM_FLD_RECHK_HI:`CRPM_FLD_RECHK_LO];
    assign scale = st_ff.ppm_tol[`CRPM_FLD_SCALE_HI:`CRPM_FLD_SCALE_LO];
    assign base_w = `CRPM_TOL_W'(ppm_delta_base);
    assign frac_w = `CRPM_TOL_W'(ppm_delta_base[`CRPM_FLD_FRAC_HI:`CRPM_FLD_FRAC_LO]);
    assign wr_lock_pwr = reg_wr && (reg_addr == `CRPM_OFS_LOCK_PWR);
    assign wr_ppm_tol = reg_wr && (reg_addr == `CRPM_OFS_PPM_TOL);

    always_comb begin
        nxt_st = st_ff;

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (wr_lock_pwr) begin
            nxt_st.lock_pwr = reg_wdata;
        end
        // done clears the fetch bit; a write in the same cycle wins
        if (st_ff.ppm_tol[`CRPM_BIT_FETCH]) begin
            nxt_st.ppm_tol[`CRPM_BIT_FETCH] = 1'b0;
        end
        if (wr_ppm_tol) begin
            nxt_st.ppm_tol = reg_wdata;
        end

        // ----------------------------------------
        // ppm error capture
        // ----------------------------------------
        if (st_ff.ppm_tol[`CRPM_BIT_FETCH]) begin
            nxt_st.ppm_result = ppm_count;
            nxt_st.lock_pwr[`CRPM_BIT_PPM_RDY] = 1'b1;
        end else if (ppm_count_valid) begin
            nxt_st.ppm_result = ppm_count;
            nxt_st.lock_pwr[`CRPM_BIT_PPM_RDY] = 1'b1;
        end

        // ----------------------------------------
        // tolerance scaling
        // ----------------------------------------
        case (scale)
            `CRPM_SCALE_X1: nxt_st.tol_scaled = base_w;
            `CRPM_SCALE_X1P: nxt_st.tol_scaled = base_w + frac_w;
            `CRPM_SCALE_X2: nxt_st.tol_scaled = base_w << 1;
            `CRPM_SCALE_X2P: nxt_st.tol_scaled = (base_w << 1) + frac_w;
            default: nxt_st.tol_scaled = base_w;
        endcase

        // ----------------------------------------
        // lock monitor
        // ----------------------------------------
        if (lock_check_tick) begin
            case (st_ff.lock_state)
                crpm_pkg::LK_UNLOCKED: begin
                    if (crit_sync) begin
                        nxt_st.lock_state = crpm_pkg::LK_LOCKED;
                        nxt_st.lock = 1'b1;
                        nxt_st.recheck_cnt = 2'h0;
                    end
                end
                crpm_pkg::LK_LOCKED: begin
                    if (!crit_sync) begin
                        if (recheck_max == 2'h0) begin
                            nxt_st.lock_state = crpm_pkg::LK_UNLOCKED;
                            nxt_st.lock = 1'b0;
                        end else begin
                            nxt_st.lock_state = crpm_pkg::LK_RECHECK;
                            nxt_st.recheck_cnt = 2'h1;
                        end
                    end
                end
                crpm_pkg::LK_RECHECK: begin
                    if (crit_sync) begin
                        nxt_st.lock_state = crpm_pkg::LK_LOCKED;
                        nxt_st.recheck_cnt = 2'h0;
                    end else if (st_ff.recheck_cnt >= recheck_max) begin
                        nxt_st.lock_state = crpm_pkg::LK_UNLOCKED;
                        nxt_st.lock = 1'b0;
                        nxt_st.recheck_cnt = 2'h0;
                    end else begin
                        nxt_st.recheck_cnt = st_ff.recheck_cnt + 2'h1;
                    end
                end
                default: begin
                    nxt_st.lock_state = crpm_pkg::LK_UNLOCKED;
                    nxt_st.lock = 1'b0;
                    nxt_st.recheck_cnt = 2'h0;
                end
            endcase
        end

        // ----------------------------------------
        // signal-loss power-down timer
        // ----------------------------------------
        if (sd_sync || st_ff.lock_pwr[`CRPM_BIT_LP_DIS]) begin
            nxt_st.pd_cnt = `CRPM_PD_CNT_W'(0);
            nxt_st.power_down = 1'b0;
        end else if (st_ff.pd_cnt >= PD_LAST) begin
            nxt_st.power_down = 1'b1;
        end else begin
            nxt_st.pd_cnt = st_ff.pd_cnt + `CRPM_PD_CNT_W'(1);
        end

        // ----------------------------------------
        // register reads
        // ----------------------------------------
        if (reg_rd) begin
            case (reg_addr)
                `CRPM_OFS_LOCK_PWR: nxt_st.rdata = st_ff.lock_pwr;
                `CRPM_OFS_PPM_TOL: nxt_st.rdata = st_ff.ppm_tol;
                default: nxt_st.rdata = `CRPM_RD_UNMAPPED;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = st_ff.rdata;
    assign cdr_lock = st_ff.lock;
    assign power_down = st_ff.power_down;
    assign ppm_result = st_ff.ppm_result;
    assign ppm_tol_scaled = st_ff.tol_scaled;

endmodule

`default_nettype wire

/* File: dv/crpm_top_asserts.sv */
// concurrent checks on the ports of the lock monitor slice
`timescale 1ns/1ps
`default_nettype none

module crpm_top_asserts #(
    parameter int unsigned PD_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic sig_detect,
    input wire logic lock_crit_ok,
    input wire logic lock_check_tick,
    input wire logic [15:0] ppm_count,
    input wire logic ppm_count_valid,
    input wire logic [7:0] ppm_delta_base,
    input wire logic cdr_lock,
    input wire logic power_down,
    input wire logic [15:0] ppm_result,
    input wire logic [9:0] ppm_tol_scaled
);
    logic [9:0] t0, t1, t2, t3;
    assign t0 = {2'h0, ppm_delta_base};
    assign t1 = t0 + {7'h00, ppm_delta_base[3:1]};
    assign t2 = {1'h0, ppm_delta_base, 1'h0};
    assign t3 = t2 + {7'h00, ppm_delta_base[3:1]};
    // shadow of the scale field, taken from writes seen on the register port
    logic [1:0] scale_sh;
    logic [9:0] t_exp;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scale_sh <= 2'h0;
        end else if (ce && reg_wr && reg_addr == 8'h35) begin
            scale_sh <= reg_wdata[7:6];
        end
    end
    always_comb begin
        case (scale_sh)
            2'h1: t_exp = t1;
            2'h2: t_exp = t2;
            2'h3: t_exp = t3;
            default: t_exp = t0;
        endcase
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_ppm_capture: assert property (ce && ppm_count_valid |=> ppm_result == $past(ppm_count))
        else $error("ppm result not captured");
    chk_ready_flag: assert property (ce && ppm_count_valid ##1 ce && reg_rd && reg_addr == 8'h34 |=> reg_rdata[7])
        else $error("ready flag missing");
    chk_fetch_capture: assert property (ce && reg_wr && reg_addr == 8'h35 && reg_wdata[5] ##1 ce
        |=> ppm_result == $past(ppm_count)) else $error("manual fetch missed");
    chk_tol_scale: assert property (ce |=> ppm_tol_scaled == $past(t_exp))
        else $error("scaled tolerance wrong");
    chk_lock_stable: assert property (ce && !lock_check_tick && !$past(lock_check_tick) |=> $stable(cdr_lock))
        else $error("lock moved without check");
    chk_lock_kept: assert property ((ce && lock_crit_ok)[*6] ##0 cdr_lock && lock_check_tick |=> cdr_lock[*2])
        else $error("lock dropped while met");
    chk_pd_rise: assert property ($rose(power_down) |-> !$past(sig_detect, 4))
        else $error("power down without loss");
    chk_pd_release: assert property ((ce && sig_detect)[*8] |-> !power_down)
        else $error("power down with signal");
endmodule

bind crpm_top crpm_top_asserts #(.PD_CYCLES(PD_CYCLES)) crpm_top_asserts_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sig_detect(sig_detect), .lock_crit_ok(lock_crit_ok), .lock_check_tick(lock_check_tick), .ppm_count(ppm_count),
    .ppm_count_valid(ppm_count_valid), .ppm_delta_base(ppm_delta_base), .cdr_lock(cdr_lock),
    .power_down(power_down), .ppm_result(ppm_result), .ppm_tol_scaled(ppm_tol_scaled));

`default_nettype wire

/* File: dv/crpm_far_end.sv */
// far-end transmitter model feeding the clock-recovery inputs
`timescale 1ns/1ps
`default_nettype none

module crpm_far_end (
    input wire logic sig_on,
    input wire logic crit_on,
    input wire logic send,
    input wire logic [15:0] value,
    output logic sig_detect,
    output logic lock_crit_ok,
    output logic ppm_count_valid,
    output logic [15:0] ppm_count
);
    assign sig_detect = sig_on;
    assign lock_crit_ok = crit_on;
    assign ppm_count_valid = send;
    // between counts the bus shows the inverse, never the last value
    assign ppm_count = send ? value : ~value;
endmodule

`default_nettype wire

/* File: dv/crpm_top_tb.sv */
// self-checking bench of the lock monitor slice
`timescale 1ns/1ps
`default_nettype none

module crpm_top_tb;
    localparam int unsigned PD = 20;
    logic ref_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, tick = 1'h0;
    logic sig_on = 1'h1, crit_on = 1'h0, send = 1'h0, ce = 1'h1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, base = 8'hF7, rdata;
    logic [15:0] value = 16'hA5C3, ppm_count, ppm_result;
    logic sig_detect, crit, valid, cdr_lock, power_down;
    logic [9:0] tol;
    int fail_count = 0, check_count = 0, cycles = 0;
    int lst[4] = '{0, 1, 2, 3};

    initial forever #5 ref_clk = ~ref_clk;

    crpm_far_end crpm_far_end_i (.sig_on(sig_on), .crit_on(crit_on), .send(send), .value(value),
        .sig_detect(sig_detect), .lock_crit_ok(crit), .ppm_count_valid(valid), .ppm_count(ppm_count));
    crpm_top #(.PD_CYCLES(PD)) crpm_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .sig_detect(sig_detect),
        .lock_crit_ok(crit), .lock_check_tick(tick), .ppm_count(ppm_count), .ppm_count_valid(valid),
        .ppm_delta_base(base), .cdr_lock(cdr_lock), .power_down(power_down), .ppm_result(ppm_result),
        .ppm_tol_scaled(tol));

    // ----------------------------------------
    // access and comparison tasks
    // ----------------------------------------
    task report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'h1;
        addr = a;
        wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'h0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_rd = 1'h1;
        addr = a;
        @(negedge ref_clk);
        reg_rd = 1'h0;
        @(negedge ref_clk);
        check({8'h00, rdata}, {8'h00, exp});
    endtask
    task tick_chk(input logic exp);
        @(negedge ref_clk);
        tick = 1'h1;
        @(negedge ref_clk);
        tick = 1'h0;
        @(negedge ref_clk);
        check({15'h0000, cdr_lock}, {15'h0000, exp});
    endtask
    function automatic logic [9:0] tol_exp(input logic [7:0] b, input logic [1:0] s);
        logic [9:0] f;
        f = s[1] ? {1'h0, b, 1'h0} : {2'h0, b};
        return s[0] ? f + {7'h00, b[3:1]} : f;
    endfunction

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        idle(3);
        arst_n = 1'h1;
        rd_chk(8'h34, 8'h3F);
        rd_chk(8'h35, 8'h1F);
        rd_chk(8'h50, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(8'h35, {s[1:0], 6'h1F});
            idle(2);
            check({6'h00, tol}, {6'h00, tol_exp(base, s[1:0])});
        end
        send = 1'h1;
        rd_chk(8'h34, 8'hBF);
        send = 1'h0;
        check(ppm_result, value);
        wr(8'h34, 8'h3F);
        rd_chk(8'h34, 8'h3F);
        wr(8'h35, 8'hE0);
        idle(2);
        check(ppm_result, ~value);
        rd_chk(8'h35, 8'hC0);
        rd_chk(8'h34, 8'hBF);
        // clock enable low: write and count pulses must leave all state frozen
        ce = 1'h0;
        send = 1'h1;
        wr(8'h34, 8'h00);
        idle(2);
        send = 1'h0;
        ce = 1'h1;
        check(ppm_result, ~value);
        rd_chk(8'h34, 8'hBF);
        for (int i = 0; i < 4; i++) begin
            wr(8'h34, {2'h0, lst[i][1:0], 4'hF});
            crit_on = 1'h1;
            idle(6);
            tick_chk(1'h1);
            crit_on = 1'h0;
            idle(6);
            repeat (lst[i]) tick_chk(1'h1);
            tick_chk(1'h0);
        end
        crit_on = 1'h1;
        idle(6);
        tick_chk(1'h1);
        crit_on = 1'h0;
        idle(6);
        repeat (2) tick_chk(1'h1);
        crit_on = 1'h1;
        idle(6);
        tick_chk(1'h1);
        crit_on = 1'h0;
        idle(6);
        repeat (3) tick_chk(1'h1);
        tick_chk(1'h0);
        sig_on = 1'h0;
        idle(PD - 6);
        check({15'h0000, power_down}, 16'h0000);
        idle(12);
        check({15'h0000, power_down}, 16'h0001);
        sig_on = 1'h1;
        idle(8);
        check({15'h0000, power_down}, 16'h0000);
        wr(8'h34, 8'h7F);
        sig_on = 1'h0;
        idle(PD + 10);
        check({15'h0000, power_down}, 16'h0000);
        report_and_stop();
    end
endmodule

`default_nettype wire
